/* cops_defs.svh */
// Register map, field positions, reset values and counts of the control block
`ifndef COPS_DEFS_SVH
`define COPS_DEFS_SVH

`define COPS_OFS_CLAMP        8'h1B
`define COPS_OFS_SLICER       8'h1D
`define COPS_OFS_INPWR        8'h1E
`define COPS_OFS_OUTFMT       8'h1F
`define COPS_OFS_ACTIVITY     8'h24

`define COPS_RST_CLAMP        8'h5B
`define COPS_RST_SLICER       8'h78
`define COPS_RST_INPWR        8'h20
`define COPS_RST_OUTFMT       8'h94

`define COPS_B_CLAMP_OVR      7
`define COPS_B_CLAMP_POL      6
`define COPS_B_AUTO_OFS       5
`define COPS_F_UPD_HI         4
`define COPS_F_UPD_LO         3
`define COPS_F_THR_HI         7
`define COPS_F_THR_LO         3
`define COPS_B_SLICER_POL     2
`define COPS_F_SEL_HI         1
`define COPS_F_SEL_LO         0
`define COPS_B_CHAN_OVR       7
`define COPS_B_CHAN_SEL       6
`define COPS_B_BW_HIGH        5
`define COPS_B_PD_AUTO        4
`define COPS_B_PD_REQ         3
`define COPS_B_PD_PIN_POL     2
`define COPS_B_FAST_SW        1
`define COPS_B_SLICER_HIZ     0
`define COPS_F_FMT_HI         7
`define COPS_F_FMT_LO         5
`define COPS_B_PRI_OE         4

`define COPS_UPD_EVERY        2'b00
`define COPS_UPD_16           2'b01
`define COPS_UPD_64           2'b10
`define COPS_UPD_VSYNC        2'b11
`define COPS_SEL_RAW_SLICER   2'b00
`define COPS_SEL_RAW_HSYNC    2'b01
`define COPS_SEL_REGEN        2'b10
`define COPS_SEL_FILTERED     2'b11
`define COPS_FMT_RGB444       3'b100
`define COPS_FMT_YCC422       3'b101
`define COPS_FMT_DDR444       3'b110

`define COPS_PINS_FULL        30'h3FFFFFFF
`define COPS_PINS_422         30'h000FFFFF
`define COPS_DEV_ADDR         7'h4C
`define COPS_ACT_WINDOW       24'd65536
`define COPS_ACT_CNT_W        24

`endif

/* cops_pkg.sv */
// Types shared by the control register block and its activity detector
`default_nettype none
`include "cops_defs.svh"
package cops_pkg;

  typedef enum logic [3:0] {
    SER_IDLE, SER_ADDR, SER_ADDR_ACK, SER_PTR, SER_PTR_ACK,
    SER_WDATA, SER_WDATA_ACK, SER_RDATA, SER_RDATA_ACK
  } cops_ser_state_t;

  typedef enum logic [1:0] {FMT_RGB444, FMT_YCC422, FMT_DDR444} cops_out_fmt_t;

  // Order matches the activity status byte, bit 7 down to bit 2
  typedef struct packed {
    logic horizontal_sync_input_zero;
    logic horizontal_sync_input_one;
    logic vsync_input_zero;
    logic vsync_input_one;
    logic green_sync_input_zero;
    logic green_sync_input_one;
  } cops_sync_in_t;

  typedef struct packed {
    logic clamp_polarity_chip;
    logic auto_channel;
    logic clamp_period;
    logic vsync_period;
    logic regenerated_sync;
    logic filtered_sync;
  } cops_analog_t;

  typedef struct packed {
    logic          clamp_polarity_select;
    logic          auto_offset_en;
    logic          offset_update;
    logic [4:0]    slicer_threshold;
    logic          slicer_sync_output_pin;
    logic          slicer_sync_oe;
    logic          channel_sel;
    logic          bandwidth_high;
    logic          powered_down;
    cops_out_fmt_t out_fmt;
    logic          ddr_mode;
    logic [29:0]   data_pin_en;
  } cops_ctrl_t;

  typedef struct packed {
    cops_ser_state_t fsm;
    logic [7:0]      shreg;
    logic [7:0]      tx;
    logic [3:0]      bit_cnt;
    logic            rw;
    logic            nack;
    logic [7:0]      ptr;
    logic            scl_prev;
    logic            sda_prev;
    logic            sda_oe;
    logic [7:0]      clamp_reg;
    logic [7:0]      slicer_reg;
    logic [7:0]      inpwr_reg;
    logic [7:0]      outfmt_reg;
    logic [5:0]      clamp_cnt;
    cops_ctrl_t      ctl;
  } cops_state_t;

  typedef struct packed {
    logic                      prev;
    logic                      active;
    logic [`COPS_ACT_CNT_W-1:0] cnt;
  } cops_det_state_t;

endpackage : cops_pkg
`default_nettype wire

/* cops_act_det.sv */
// Activity detector for one sync input: active while edges keep arriving
`timescale 1ns/1ns
`default_nettype none
`include "cops_defs.svh"
module cops_act_det
  import cops_pkg::*;
#(
  parameter logic [`COPS_ACT_CNT_W-1:0] WINDOW = `COPS_ACT_WINDOW
) (
  // Clock and reset
  input  wire logic ref_clk_in,
  input  wire logic reset_in,
  // Monitored sync and result
  input  wire logic sig_in,
  output logic      active_out
);

  cops_det_state_t st_ff;
  cops_det_state_t nxt_st;

  // A held-high or held-low input lets the window run out
  always_comb begin
    nxt_st = st_ff;
    nxt_st.prev = sig_in;
    if (sig_in != st_ff.prev) begin
      nxt_st.cnt    = WINDOW;
      nxt_st.active = 1'b1;
    end else if (st_ff.cnt != '0) begin
      nxt_st.cnt = st_ff.cnt - 1'b1;
    end else begin
      nxt_st.active = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign active_out = st_ff.active;

endmodule : cops_act_det
`default_nettype wire

/* cops_ctrl_regs.sv */
// Clamp, offset, slicer, input, power and output control registers on a 2-wire port
`timescale 1ns/1ns
`default_nettype none
`include "cops_defs.svh"
// How it works
// - User clamp polarity bit applies only under override; resets high.
// - Override clear lets the chip pick clamp polarity; override resets clear.
// - Bit five selects automatic offset when set, manual when clear.
// - Offset update every clamp, every 16, every 64, or once per vsync.
// - Five-bit slicer threshold in 8 mV steps, reset code gives 120 mV.
// - Slicer sync pin polarity: clear active low, set active high.
// - Slicer pin source: raw slicer, raw hsync, regenerated or filtered sync.
// - Channel override clear leaves input choice to automatic logic.
// - Under override, select bit picks channel zero or one.
// - Bandwidth bit picks low when clear, high when set; resets high.
// - Power-down control bit picks manual when clear, automatic when set.
// - Automatic mode stays powered while any hsync or green sync is active.
// - Manual mode powers down on register bit or asserted power-down pin.
// - Pin polarity bit makes power-down pin active low or active high.
// - Fast switching keeps the chip powered and only floats outputs.
// - During power-down a set bit floats the slicer sync pin.
// - Output format codes give 4:4:4 RGB, 4:2:2 YCbCr or 4:4:4 DDR.
// - 4:2:2 drives 20 data pins, DDR changes data on both edges.
// - Primary output bit floats data when clear, enables when set.
module cops_ctrl_regs
  import cops_pkg::*;
#(
  parameter logic [6:0]                  DEV_ADDR   = `COPS_DEV_ADDR,
  parameter logic [`COPS_ACT_CNT_W-1:0]  ACT_WINDOW = `COPS_ACT_WINDOW
) (
  // Clock and reset
  input  wire logic    ref_clk_in,
  input  wire logic    reset_in,
  // Two-wire serial control port
  input  wire logic    scl_in,
  input  wire logic    sda_in,
  output logic         sda_out,
  output logic         sda_oe_out,
  // Sync pins and analog-side status
  input  wire cops_sync_in_t sync_in,
  input  wire cops_analog_t  analog_in,
  input  wire logic    power_down_pin_in,
  // Control outputs to the datapath
  output cops_ctrl_t   ctl_out
);

  cops_state_t st_ff;
  cops_state_t nxt_st;
  logic [5:0]  act;
  logic [7:0]  rd_data;
  logic        start_cond;
  logic        stop_cond;
  logic        scl_rise;
  logic        scl_fall;
  logic        chan_eff;
  logic        pd_req;
  logic        upd_strobe;
  logic        src_sel;

  localparam cops_state_t RST_STATE = '{
    fsm: SER_IDLE, shreg: 8'h00, tx: 8'h00, bit_cnt: 4'h0, rw: 1'b0, nack: 1'b0,
    ptr: 8'h00, scl_prev: 1'b1, sda_prev: 1'b1, sda_oe: 1'b0,
    clamp_reg: `COPS_RST_CLAMP, slicer_reg: `COPS_RST_SLICER,
    inpwr_reg: `COPS_RST_INPWR, outfmt_reg: `COPS_RST_OUTFMT,
    clamp_cnt: 6'h00, ctl: '0};

  // Sync activity detectors, one per monitored input
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_act
      cops_act_det #(.WINDOW(ACT_WINDOW)) u_det (
        .ref_clk_in (ref_clk_in),
        .reset_in   (reset_in),
        .sig_in     (sync_in[gi]),
        .active_out (act[gi])
      );
    end
  endgenerate

  assign start_cond = st_ff.scl_prev & scl_in & st_ff.sda_prev & ~sda_in;
  assign stop_cond  = st_ff.scl_prev & scl_in & ~st_ff.sda_prev & sda_in;
  assign scl_rise   = scl_in & ~st_ff.scl_prev;
  assign scl_fall   = ~scl_in & st_ff.scl_prev;

  // Unmapped addresses read as zero
  always_comb begin
    unique case (st_ff.ptr)
      `COPS_OFS_CLAMP:    rd_data = st_ff.clamp_reg;
      `COPS_OFS_SLICER:   rd_data = st_ff.slicer_reg;
      `COPS_OFS_INPWR:    rd_data = st_ff.inpwr_reg;
      `COPS_OFS_OUTFMT:   rd_data = st_ff.outfmt_reg;
      `COPS_OFS_ACTIVITY: rd_data = {act, 2'b00};
      default:            rd_data = 8'h00;
    endcase
  end

  assign chan_eff = st_ff.inpwr_reg[`COPS_B_CHAN_OVR] ? st_ff.inpwr_reg[`COPS_B_CHAN_SEL]
                                                      : analog_in.auto_channel;

  always_comb begin
    if (st_ff.inpwr_reg[`COPS_B_PD_AUTO]) begin
      // hsync or green sync; vsync ignored
      pd_req = ~(act[5] | act[4] | act[1] | act[0]);
    end else begin
      pd_req = st_ff.inpwr_reg[`COPS_B_PD_REQ] |
               (power_down_pin_in == st_ff.inpwr_reg[`COPS_B_PD_PIN_POL]);
    end
  end

  always_comb begin
    unique case (st_ff.clamp_reg[`COPS_F_UPD_HI:`COPS_F_UPD_LO])
      `COPS_UPD_EVERY: upd_strobe = analog_in.clamp_period;
      `COPS_UPD_16:    upd_strobe = analog_in.clamp_period & (st_ff.clamp_cnt[3:0] == 4'hF);
      `COPS_UPD_64:    upd_strobe = analog_in.clamp_period & (st_ff.clamp_cnt == 6'h3F);
      `COPS_UPD_VSYNC: upd_strobe = analog_in.vsync_period;
    endcase
  end

  always_comb begin
    unique case (st_ff.slicer_reg[`COPS_F_SEL_HI:`COPS_F_SEL_LO])
      `COPS_SEL_RAW_SLICER: src_sel = chan_eff ? sync_in.green_sync_input_one
                                               : sync_in.green_sync_input_zero;
      `COPS_SEL_RAW_HSYNC:  src_sel = chan_eff ? sync_in.horizontal_sync_input_one
                                               : sync_in.horizontal_sync_input_zero;
      `COPS_SEL_REGEN:      src_sel = analog_in.regenerated_sync;
      `COPS_SEL_FILTERED:   src_sel = analog_in.filtered_sync;
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.scl_prev = scl_in;
    nxt_st.sda_prev = sda_in;
    if (start_cond) begin
      // Repeated start is legal in any state
      nxt_st.fsm     = SER_ADDR;
      nxt_st.bit_cnt = 4'h0;
      nxt_st.sda_oe  = 1'b0;
    end else if (stop_cond) begin
      nxt_st.fsm    = SER_IDLE;
      nxt_st.sda_oe = 1'b0;
    end else begin
      unique case (st_ff.fsm)
        SER_IDLE: begin
          nxt_st.sda_oe = 1'b0;
        end
        SER_ADDR, SER_PTR, SER_WDATA: begin
          if (scl_rise) begin
            nxt_st.shreg   = {st_ff.shreg[6:0], sda_in};
            nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
          end else if (scl_fall && st_ff.bit_cnt == 4'h8) begin
            nxt_st.sda_oe = 1'b1;
            if (st_ff.fsm == SER_ADDR) begin
              // Foreign addresses are not acknowledged
              nxt_st.rw     = st_ff.shreg[0];
              nxt_st.fsm    = (st_ff.shreg[7:1] == DEV_ADDR) ? SER_ADDR_ACK : SER_IDLE;
              nxt_st.sda_oe = (st_ff.shreg[7:1] == DEV_ADDR);
            end else if (st_ff.fsm == SER_PTR) begin
              nxt_st.ptr = st_ff.shreg;
              nxt_st.fsm = SER_PTR_ACK;
            end else begin
              // Read-only and unmapped addresses ignore writes
              unique case (st_ff.ptr)
                `COPS_OFS_CLAMP:  nxt_st.clamp_reg  = st_ff.shreg;
                `COPS_OFS_SLICER: nxt_st.slicer_reg = st_ff.shreg;
                `COPS_OFS_INPWR:  nxt_st.inpwr_reg  = st_ff.shreg;
                `COPS_OFS_OUTFMT: nxt_st.outfmt_reg = st_ff.shreg;
                default:          nxt_st.ptr        = st_ff.ptr;
              endcase
              nxt_st.ptr = st_ff.ptr + 8'h01;
              nxt_st.fsm = SER_WDATA_ACK;
            end
          end
        end
        SER_PTR_ACK, SER_WDATA_ACK: begin
          if (scl_fall) begin
            nxt_st.sda_oe  = 1'b0;
            nxt_st.bit_cnt = 4'h0;
            nxt_st.fsm     = SER_WDATA;
          end
        end
        SER_ADDR_ACK, SER_RDATA_ACK: begin
          if (scl_rise) begin
            nxt_st.nack = sda_in & (st_ff.fsm == SER_RDATA_ACK);
          end else if (scl_fall) begin
            nxt_st.bit_cnt = 4'h0;
            if (st_ff.fsm == SER_ADDR_ACK && !st_ff.rw) begin
              nxt_st.sda_oe = 1'b0;
              nxt_st.fsm    = SER_PTR;
            end else if (st_ff.nack) begin
              nxt_st.sda_oe = 1'b0;
              nxt_st.fsm    = SER_IDLE;
            end else begin
              // Read pointer advances as each byte is loaded
              nxt_st.tx     = rd_data;
              nxt_st.sda_oe = ~rd_data[7];
              nxt_st.ptr    = st_ff.ptr + 8'h01;
              nxt_st.fsm    = SER_RDATA;
            end
          end
        end
        SER_RDATA: begin
          if (scl_rise) begin
            nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (st_ff.bit_cnt == 4'h8) begin
              nxt_st.sda_oe = 1'b0;
              nxt_st.fsm    = SER_RDATA_ACK;
            end else begin
              nxt_st.tx     = {st_ff.tx[6:0], 1'b0};
              nxt_st.sda_oe = ~st_ff.tx[6];
            end
          end
        end
        default: begin
          nxt_st.fsm    = SER_IDLE;
          nxt_st.sda_oe = 1'b0;
        end
      endcase
    end

    nxt_st.ctl.auto_offset_en = st_ff.clamp_reg[`COPS_B_AUTO_OFS];
    if (st_ff.clamp_reg[`COPS_B_AUTO_OFS]) begin
      nxt_st.clamp_cnt = st_ff.clamp_cnt + {5'h00, analog_in.clamp_period};
      nxt_st.ctl.offset_update = upd_strobe;
    end else begin
      nxt_st.clamp_cnt         = 6'h00;
      nxt_st.ctl.offset_update = 1'b0;
    end

    nxt_st.ctl.clamp_polarity_select = st_ff.clamp_reg[`COPS_B_CLAMP_OVR] ?
                                       st_ff.clamp_reg[`COPS_B_CLAMP_POL] :
                                       analog_in.clamp_polarity_chip;
    nxt_st.ctl.slicer_threshold = st_ff.slicer_reg[`COPS_F_THR_HI:`COPS_F_THR_LO];
    nxt_st.ctl.slicer_sync_output_pin = st_ff.slicer_reg[`COPS_B_SLICER_POL] ? src_sel
                                                                              : ~src_sel;
    nxt_st.ctl.slicer_sync_oe = ~(pd_req & st_ff.inpwr_reg[`COPS_B_SLICER_HIZ]);
    nxt_st.ctl.channel_sel    = chan_eff;
    nxt_st.ctl.bandwidth_high = st_ff.inpwr_reg[`COPS_B_BW_HIGH];
    nxt_st.ctl.powered_down = pd_req & ~st_ff.inpwr_reg[`COPS_B_FAST_SW];

    unique case (st_ff.outfmt_reg[`COPS_F_FMT_HI:`COPS_F_FMT_LO])
      `COPS_FMT_YCC422: nxt_st.ctl.out_fmt = FMT_YCC422;
      `COPS_FMT_DDR444: nxt_st.ctl.out_fmt = FMT_DDR444;
      default:          nxt_st.ctl.out_fmt = FMT_RGB444;
    endcase
    nxt_st.ctl.ddr_mode = (nxt_st.ctl.out_fmt == FMT_DDR444);
    if (!st_ff.outfmt_reg[`COPS_B_PRI_OE] || pd_req) begin
      nxt_st.ctl.data_pin_en = 30'h00000000;
    end else if (nxt_st.ctl.out_fmt == FMT_YCC422) begin
      nxt_st.ctl.data_pin_en = `COPS_PINS_422;
    end else begin
      nxt_st.ctl.data_pin_en = `COPS_PINS_FULL;
    end
  end

  // Registers keep power-up values; host must write 011 into the clamp low bits
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      st_ff <= RST_STATE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Open drain: only ever pulls low
  assign sda_out    = 1'b0;
  assign sda_oe_out = st_ff.sda_oe;
  assign ctl_out    = st_ff.ctl;

  property p_clamp_user;
    @(posedge ref_clk_in) disable iff (reset_in)
    st_ff.clamp_reg[7] |=> ctl_out.clamp_polarity_select == $past(st_ff.clamp_reg[6]);
  endproperty
  a_clamp_user: assert property (p_clamp_user) else $error("clamp polarity not user");

  property p_clamp_chip;
    @(posedge ref_clk_in) disable iff (reset_in)
    !st_ff.clamp_reg[7] |=> ctl_out.clamp_polarity_select == $past(analog_in.clamp_polarity_chip);
  endproperty
  a_clamp_chip: assert property (p_clamp_chip) else $error("clamp polarity not chip");

  property p_no_update;
    @(posedge ref_clk_in) disable iff (reset_in)
    (!st_ff.clamp_reg[5]) [*2] |=> !ctl_out.offset_update;
  endproperty
  a_no_update: assert property (p_no_update) else $error("update with offset off");

  property p_upd_every;
    @(posedge ref_clk_in) disable iff (reset_in)
    st_ff.clamp_reg[5] && st_ff.clamp_reg[4:3] == 2'b00 && analog_in.clamp_period
      |=> ctl_out.offset_update;
  endproperty
  a_upd_every: assert property (p_upd_every) else $error("missed clamp update");

  property p_threshold;
    @(posedge ref_clk_in) disable iff (reset_in)
    1'b1 |=> ctl_out.slicer_threshold == $past(st_ff.slicer_reg[7:3]);
  endproperty
  a_threshold: assert property (p_threshold) else $error("threshold mismatch");

  property p_hsync_route;
    @(posedge ref_clk_in) disable iff (reset_in)
    st_ff.slicer_reg[2:0] == 3'b101
      |=> ctl_out.slicer_sync_output_pin == $past(chan_eff ? sync_in.horizontal_sync_input_one
                                                            : sync_in.horizontal_sync_input_zero);
  endproperty
  a_hsync_route: assert property (p_hsync_route) else $error("slicer pin route");

  property p_chan_user;
    @(posedge ref_clk_in) disable iff (reset_in)
    st_ff.inpwr_reg[7:6] == 2'b11 |=> ctl_out.channel_sel;
  endproperty
  a_chan_user: assert property (p_chan_user) else $error("channel override lost");

  property p_manual_pd;
    @(posedge ref_clk_in) disable iff (reset_in)
    st_ff.inpwr_reg[4] == 1'b0 && st_ff.inpwr_reg[3] && !st_ff.inpwr_reg[1]
      |=> ctl_out.powered_down && ctl_out.data_pin_en == 30'h00000000;
  endproperty
  a_manual_pd: assert property (p_manual_pd) else $error("manual power-down ignored");

  property p_fast_sw;
    @(posedge ref_clk_in) disable iff (reset_in)
    pd_req && st_ff.inpwr_reg[1] |=> !ctl_out.powered_down && ctl_out.data_pin_en == 30'h0;
  endproperty
  a_fast_sw: assert property (p_fast_sw) else $error("fast switch powered down");

  property p_slicer_hiz;
    @(posedge ref_clk_in) disable iff (reset_in)
    pd_req && st_ff.inpwr_reg[0] |=> !ctl_out.slicer_sync_oe;
  endproperty
  a_slicer_hiz: assert property (p_slicer_hiz) else $error("slicer pin not floated");

  property p_fmt_default;
    @(posedge ref_clk_in) disable iff (reset_in)
    st_ff.outfmt_reg[7] == 1'b0 || st_ff.outfmt_reg[6:5] == 2'b11 |=> ctl_out.out_fmt == FMT_RGB444;
  endproperty
  a_fmt_default: assert property (p_fmt_default) else $error("undefined format not RGB");

  property p_pins_422;
    @(posedge ref_clk_in) disable iff (reset_in)
    st_ff.outfmt_reg[7:4] == 4'hB && !pd_req |=> ctl_out.data_pin_en == 30'h000FFFFF;
  endproperty
  a_pins_422: assert property (p_pins_422) else $error("4:2:2 pin count wrong");

endmodule : cops_ctrl_regs
`default_nettype wire

/* cops_host.sv */
// Two-wire host model that drives the serial control port
`timescale 1ns/1ns
`default_nettype none
module cops_host (
  // Clock and wire level
  input  wire logic ref_clk_in,
  input  wire logic sda_in,
  // Host drives
  output logic      scl_out,
  output logic      sda_low_out
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // Changes land 2 ns after an edge, never on it
  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk_in);
    #2;
  endtask : hold
  // Also serves as repeated start from SCL low
  task automatic start();
    scl_out = 1'b1;
    hold(4);
    sda_low_out = 1'b1;
    hold(4);
    scl_out = 1'b0;
    hold(4);
  endtask : start
  task automatic stop();
    sda_low_out = 1'b1;
    hold(4);
    scl_out = 1'b1;
    hold(4);
    sda_low_out = 1'b0;
    hold(4);
  endtask : stop
  // Sample mid-high, well clear of the data change after SCL falls
  task automatic xbit(input logic b, output logic r);
    sda_low_out = ~b;
    hold(4);
    scl_out = 1'b1;
    hold(4);
    r = sda_in;
    hold(4);
    scl_out = 1'b0;
    hold(4);
  endtask : xbit
  // Ninth bit: 1 releases the wire (ack sampling or read nack)
  task automatic xbyte(input logic [7:0] d, input logic last, output logic [7:0] q,
                       output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], q[i]);
    end
    xbit(last, r);
    ack = ~r;
  endtask : xbyte
endmodule : cops_host
`default_nettype wire

/* clamp_offset_sync_power_output_ctrl_bench.sv */
// Self-checking bench for the control register block
`timescale 1ns/1ns
`default_nettype none
`include "cops_defs.svh"
module clamp_offset_sync_power_output_ctrl_bench;
  import cops_pkg::*;
  logic ref_clk_in = 1'b0;
  logic reset_in, scl, sda_low, sda_oe, sda_dout, pd_pin;
  wire logic sda_w = ~(sda_low | sda_oe);
  cops_sync_in_t sync_in;
  cops_analog_t  analog_in;
  cops_ctrl_t    ctl;
  logic [7:0] d, q;
  logic a;
  int n_mismatch = 0;
  int tests_run = 0;
  int n_upd = 0;
  logic [7:0] ofs [5] = '{8'h1B, 8'h1D, 8'h1E, 8'h1F, 8'h30};
  logic [7:0] rsv [5] = '{`COPS_RST_CLAMP, `COPS_RST_SLICER, `COPS_RST_INPWR,
                          `COPS_RST_OUTFMT, 8'h00};
  // Entry: input_and_power_control value, pin, powered_down, slicer oe, full pins
  logic [11:0] pt [8] = '{12'h243, 12'h24E, 12'h20B, 12'h206, 12'h2C6, 12'h2EA,
                          12'h25C, 12'h253};
  always #10 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) if (ctl.offset_update === 1'b1) n_upd++;
  cops_host host_i (.ref_clk_in(ref_clk_in), .sda_in(sda_w), .scl_out(scl),
                    .sda_low_out(sda_low));
  cops_ctrl_regs #(.DEV_ADDR(`COPS_DEV_ADDR), .ACT_WINDOW(24'd16)) cops_ctrl_regs_i (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_dout), .sda_oe_out(sda_oe), .sync_in(sync_in), .analog_in(analog_in),
    .power_down_pin_in(pd_pin), .ctl_out(ctl));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] p, input logic [7:0] v);
    host_i.start();
    host_i.xbyte({`COPS_DEV_ADDR, 1'b0}, 1'b1, q, a);
    host_i.xbyte(p, 1'b1, q, a);
    host_i.xbyte(v, 1'b1, q, a);
    chk("ack", 1, a);
    host_i.stop();
    host_i.hold(3);
  endtask : wr
  task automatic rd(input logic [7:0] p, output logic [7:0] v);
    host_i.start();
    host_i.xbyte({`COPS_DEV_ADDR, 1'b0}, 1'b1, q, a);
    host_i.xbyte(p, 1'b1, q, a);
    host_i.start();
    host_i.xbyte({`COPS_DEV_ADDR, 1'b1}, 1'b1, q, a);
    host_i.xbyte(8'hFF, 1'b1, v, a);
    host_i.stop();
  endtask : rd
  task automatic pulse(input logic vs);
    analog_in.clamp_period = ~vs;
    analog_in.vsync_period = vs;
    host_i.hold(1);
    analog_in = '0;
    host_i.hold(2);
  endtask : pulse
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run
  initial begin
    #1500000;
    n_mismatch++;
    $display("[ERR] watchdog expected finish seen hang");
    complete_run();
  end
  initial begin
    reset_in = 1'b1;
    sync_in = '0;
    analog_in = '0;
    pd_pin = 1'b1;
    repeat (6) @(posedge ref_clk_in);
    #2 reset_in = 1'b0;
    host_i.hold(4);
    chk("bw", 1, ctl.bandwidth_high);
    chk("thr", 5'h0F, ctl.slicer_threshold);
    chk("pins", `COPS_PINS_FULL, ctl.data_pin_en);
    for (int i = 0; i < 5; i++) begin
      rd(ofs[i], d);
      chk("regval", rsv[i], d);
    end
    $display("reset test done");
    pd_pin = 1'b0;
    wr(8'h1E, 8'h24);
    wr(8'h1B, 8'hC3);
    chk("clamp", 1, ctl.clamp_polarity_select);
    wr(8'h1B, 8'h83);
    chk("clamp", 0, ctl.clamp_polarity_select);
    analog_in.clamp_polarity_chip = 1'b1;
    wr(8'h1B, 8'h03);
    chk("clamp", 1, ctl.clamp_polarity_select);
    analog_in = '0;
    $display("clamp test done");
    for (int m = 0; m < 4; m++) begin
      wr(8'h1B, {3'b001, m[1:0], 3'b011});
      chk("auto", 1, ctl.auto_offset_en);
      n_upd = 0;
      repeat (128) pulse(1'b0);
      repeat (3) pulse(1'b1);
      chk("updates", m == 3 ? 3 : 128 >> (m == 0 ? 0 : m == 1 ? 4 : 6), n_upd);
    end
    wr(8'h1B, 8'h03);
    n_upd = 0;
    repeat (20) pulse(1'b0);
    chk("updates", 0, n_upd);
    $display("offset test done");
    wr(8'h1E, 8'hE4);
    chk("chan", 1, ctl.channel_sel);
    sync_in.green_sync_input_one = 1'b1;
    analog_in.regenerated_sync = 1'b1;
    // Hsync and filtered sync swap levels with the polarity bit; 72 holds pin levels
    for (int k = 0; k < 8; k++) begin
      sync_in.horizontal_sync_input_one = k[2];
      analog_in.filtered_sync = ~k[2];
      wr(8'h1D, {5'h1F, k[2:0]});
      chk("slpin", (8'h72 >> k) & 1, ctl.slicer_sync_output_pin);
    end
    chk("thr", 5'h1F, ctl.slicer_threshold);
    analog_in.auto_channel = 1'b1;
    wr(8'h1E, 8'h24);
    chk("chan", 1, ctl.channel_sel);
    $display("slicer test done");
    for (int i = 0; i < 8; i++) begin
      pd_pin = pt[i][3];
      wr(8'h1E, pt[i][11:4]);
      chk("pd", pt[i][2], ctl.powered_down);
      chk("sloe", pt[i][1], ctl.slicer_sync_oe);
      chk("pins", pt[i][0] ? `COPS_PINS_FULL : 30'h0, ctl.data_pin_en);
    end
    wr(8'h1E, 8'h30);
    host_i.hold(40);
    chk("pd", 1, ctl.powered_down);
    repeat (12) begin
      sync_in.horizontal_sync_input_zero = ~sync_in.horizontal_sync_input_zero;
      host_i.hold(4);
    end
    chk("pd", 0, ctl.powered_down);
    host_i.hold(60);
    chk("pd", 1, ctl.powered_down);
    pd_pin = 1'b0;
    wr(8'h1E, 8'h04);
    chk("bw", 0, ctl.bandwidth_high);
    $display("power test done");
    for (int c = 0; c < 8; c++) begin
      wr(8'h1F, {c[2:0], 5'h14});
      chk("fmt", c == 5 ? FMT_YCC422 : c == 6 ? FMT_DDR444 : FMT_RGB444, ctl.out_fmt);
      chk("ddr", c == 6, ctl.ddr_mode);
      chk("pins", c == 5 ? `COPS_PINS_422 : `COPS_PINS_FULL, ctl.data_pin_en);
    end
    wr(8'h1F, 8'h84);
    chk("pins", 0, ctl.data_pin_en);
    rd(8'h1F, d);
    chk("outfmt", 8'h84, d);
    $display("format test done");
    complete_run();
  end
endmodule : clamp_offset_sync_power_output_ctrl_bench
`default_nettype wire
